// File: include/slr_pkg.sv
// constants and types shared by the receive lock and rate controller
package slr_pkg;
  // register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_ALIGN = 4'h8;
  localparam logic [3:0] ADDR_STAMP = 4'hC;
  // control field positions
  localparam int CTRL_TRIPLE_BIT = 0;
  localparam int CTRL_TOL_LSB = 4;
  localparam int CTRL_LOST_LSB = 8;
  // values after reset
  localparam logic CTRL_TRIPLE_RST = 1'b0;
  localparam logic [1:0] CTRL_TOL_RST = 2'h2;
  localparam logic [7:0] CTRL_LOST_RST = 8'h08;
  // status field positions
  localparam int ST_STD_LSB = 4;
  localparam int ST_BUSY_BIT = 6;
  localparam int ST_STATE_LSB = 8;
  // standard codes on the reconfiguration select
  localparam logic [1:0] STD_SD = 2'h0;
  localparam logic [1:0] STD_HD = 2'h1;
  localparam logic [1:0] STD_3G = 2'h2;
  // oversampling factors for sd reception
  localparam logic [3:0] OS_SD = 4'h5;
  localparam logic [3:0] OS_TRIPLE = 4'hB;
  // counts
  localparam logic [2:0] TRS_LOCK_LINES = 3'h6;
  localparam logic [15:0] LINE_LIMIT_WORDS = 16'hFFFF;
  localparam logic [2:0] FRAME_STABLE = 3'h3;
  // timeout before rate detection restarts
  localparam int TIMEOUT_US = 100000;
  localparam int CLK_MHZ = 10;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
  typedef enum logic [5:0] {
    S_DETECT = 6'h01,
    S_REQ = 6'h02,
    S_WAIT = 6'h04,
    S_TRAIN = 6'h08,
    S_LOCK = 6'h10,
    S_RUN = 6'h20
  } slr_state_type;
endpackage

// File: design/slr_oversample.sv
// recovery of sd bits from a fixed-rate oversampled stream
`timescale 1ns/1ns
`default_nettype none
module slr_oversample (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // control
  input wire logic enable,
  input wire logic [3:0] os_factor,
  // oversampled input
  input wire logic sample,
  input wire logic sample_valid,
  // recovered bits
  output logic sd_bit,
  output logic sd_bit_valid
);
  logic [3:0] phase;
  logic last;
  logic [3:0] mid;
  assign mid = {1'b0, os_factor[3:1]};
  // realign on every transition so the pick stays mid-bit
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 4'h0;
      last <= 1'b0;
    end else if (enable && sample_valid) begin
      last <= sample;
      if (sample != last) begin
        phase <= 4'h1;
      end else if (phase == os_factor - 4'h1) begin
        phase <= 4'h0;
      end else begin
        phase <= phase + 4'h1;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sd_bit <= 1'b0;
      sd_bit_valid <= 1'b0;
    end else begin
      sd_bit_valid <= enable && sample_valid && phase == mid;
      if (enable && sample_valid && phase == mid) begin
        sd_bit <= sample;
      end
    end
  end
endmodule // slr_oversample
`default_nettype wire

// File: design/slr_frame_lock.sv
// frame lock from line counts at field and vertical edges
`timescale 1ns/1ns
`default_nettype none
module slr_frame_lock
  import slr_pkg::*;
#(
  parameter logic [2:0] STABLE = slr_pkg::FRAME_STABLE
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clr,
  // timing reference input
  input wire logic eav,
  input wire logic f_bit,
  input wire logic v_bit,
  // lock
  output logic frame_locked
);
  logic f_q;
  logic v_q;
  logic [10:0] line_cnt;
  logic [3:0] edge_hit;
  logic [3:0] match;
  logic [3:0] bad;
  logic boundary;
  logic [2:0] stable_cnt;
  assign edge_hit = eav ? {f_q & ~f_bit, ~f_q & f_bit, v_q & ~v_bit, ~v_q & v_bit} : 4'h0;
  assign boundary = edge_hit[0] && !f_bit;
  generate
    for (genvar i = 0; i < 4; i++) begin : g_edge
      logic [10:0] cur;
      logic [10:0] prev;
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          cur <= 11'h000;
          prev <= 11'h000;
        end else if (clr) begin
          cur <= 11'h000;
          prev <= 11'h000;
        end else begin
          if (edge_hit[i]) begin
            cur <= line_cnt;
          end
          if (boundary) begin
            prev <= edge_hit[i] ? line_cnt : cur;
          end
        end
      end
      assign match[i] = (edge_hit[i] ? line_cnt : cur) == prev;
      assign bad[i] = edge_hit[i] && line_cnt != prev;
    end
  endgenerate
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      f_q <= 1'b0;
      v_q <= 1'b0;
      line_cnt <= 11'h000;
    end else if (eav) begin
      f_q <= f_bit;
      v_q <= v_bit;
      line_cnt <= boundary ? 11'h001 : line_cnt + 11'h001;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stable_cnt <= 3'h0;
      frame_locked <= 1'b0;
    end else if (clr) begin
      stable_cnt <= 3'h0;
      frame_locked <= 1'b0;
    end else if (frame_locked && |bad) begin
      stable_cnt <= 3'h0;
      frame_locked <= 1'b0;
    end else if (boundary) begin
      if (&match) begin
        if (stable_cnt != STABLE) begin
          stable_cnt <= stable_cnt + 3'h1;
        end
        frame_locked <= stable_cnt + 3'h1 >= STABLE;
      end else begin
        stable_cnt <= 3'h0;
        frame_locked <= 1'b0;
      end
    end
  end
endmodule // slr_frame_lock
`default_nettype wire

// File: design/slr_rx_ctrl.sv
// receive lock and rate controller: rate hunt, reconfig handshake, trs lock
// Overview of operation
// - sd input is oversampled at fixed rate; picker recovers the original bits
// - while receiving sd the receive pll stays locked to the reference
// - hd: train on reference, then track data; retrain after no signal
// - coarse rate pick, reprogram request, then attempt to lock
// - no valid data within timeout after reprogramming: reset path, detect again
// - sample enables at each detection; reprogram only when the setting changes
// - one valid trs sets the signal-present flag
// - present flag clears after set lines with no eav; then relock
// - aligner takes a new alignment after two consecutive matching trs
// - word counter per word; stamps taken at each eav and sav
// - six consistent lines assert trs lock on status bit 3
// - up to tolerance misses set missed flag only; good eav clears it
// - tolerance two: third consecutive miss drops trs lock
// - frame lock from line counts at f and v edges, stable over frames
// - frame lock drops on bad sync, frame mismatch, or trs lock loss
// - frame lock low marks received video as unreliable
// - triple mode: sd at elevenfold, sharing the 3g setting
// - multi-standard receivers reprogram; single-standard ones never do
// - drive standard, request; wait done low then high; withdraw request
// - both resets held while reprogramming; analog then digital release
// - crc error may show during reprogramming
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module slr_rx_ctrl #(
  parameter int TIMEOUT = slr_pkg::TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // transceiver control
  input wire logic pll_locked,
  output logic rx_analog_reset,
  output logic rx_digital_reset,
  output logic rx_lock_to_ref,
  output logic rx_lock_to_data,
  // reconfiguration handshake
  output logic [1:0] rx_std,
  output logic start_reconfig,
  input wire logic reconfig_done,
  // standards allowed: sd, hd, 3g
  input wire logic [2:0] standard_enable_inputs,
  // oversampled sd stream
  input wire logic os_sample,
  input wire logic os_sample_valid,
  output logic sd_bit,
  output logic sd_bit_valid,
  // received words and trs detection
  input wire logic word_valid,
  input wire logic trs_seen,
  input wire logic trs_is_eav,
  input wire logic [4:0] trs_align,
  input wire logic f_bit,
  input wire logic v_bit,
  input wire logic crc_error_in,
  // status
  output logic [4:0] word_align,
  output logic [3:0] rx_status,
  output logic video_valid,
  output logic crc_error
);
  import slr_pkg::*;
  slr_state_type state;
  slr_state_type next_state;
  logic triple;
  logic [1:0] tol;
  logic [7:0] lost_lim;
  logic rd_ack;
  logic [31:0] rd_mux;
  logic [23:0] tmr;
  logic timeout;
  logic [1:0] cand;
  logic [1:0] prog_set;
  logic prog_valid;
  logic multi;
  logic need_prog;
  logic sig_present;
  logic sig_lost;
  logic [7:0] lost_lines;
  logic missed;
  logic trs_locked;
  logic frame_locked;
  logic path_clr;
  logic pend_valid;
  logic [4:0] pend_align;
  logic acc;
  logic acc_eav;
  logic acc_sav;
  logic [15:0] word_cnt;
  logic [15:0] eav_stamp;
  logic [15:0] sav_stamp;
  logic [15:0] since;
  logic [15:0] line_len;
  logic [15:0] line_lim;
  logic len_ok;
  logic [15:0] sav_off;
  logic sav_match;
  logic [2:0] consist;
  logic [2:0] miss_cnt;
  logic line_end;
  logic good_eav;
  logic miss;

  // first enabled standard after the current one, wrapping
  function automatic logic [1:0] next_std(input logic [1:0] cur, input logic [2:0] en);
    logic [1:0] s;
    next_std = cur;
    s = cur;
    for (int k = 0; k < 3; k++) begin
      s = (s == STD_3G) ? STD_SD : s + 2'h1;
      if (en[s] && next_std == cur) begin
        next_std = s;
      end
    end
  endfunction

  // sd shares the 3g transceiver setting in triple mode
  function automatic logic [1:0] setting_of(input logic [1:0] s, input logic tri_mode);
    setting_of = (tri_mode && s == STD_SD) ? STD_3G : s;
  endfunction

  // register bus: writes take effect at once, reads wait one cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      triple <= CTRL_TRIPLE_RST;
      tol <= CTRL_TOL_RST;
      lost_lim <= CTRL_LOST_RST;
    end else if (avs_write && avs_address == ADDR_CTRL) begin
      triple <= avs_writedata[CTRL_TRIPLE_BIT];
      tol <= avs_writedata[CTRL_TOL_LSB +: 2];
      lost_lim <= avs_writedata[CTRL_LOST_LSB +: 8];
    end
  end
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address == ADDR_CTRL) begin
      rd_mux[CTRL_TRIPLE_BIT] = triple;
      rd_mux[CTRL_TOL_LSB +: 2] = tol;
      rd_mux[CTRL_LOST_LSB +: 8] = lost_lim;
    end else if (avs_address == ADDR_STATUS) begin
      rd_mux[3:0] = rx_status;
      rd_mux[ST_STD_LSB +: 2] = rx_std;
      rd_mux[ST_BUSY_BIT] = start_reconfig;
      rd_mux[ST_STATE_LSB +: 6] = state;
    end else if (avs_address == ADDR_ALIGN) begin
      rd_mux[4:0] = word_align;
    end else if (avs_address == ADDR_STAMP) begin
      rd_mux = {sav_stamp, eav_stamp};
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack <= avs_read && !rd_ack;
      if (avs_read && !rd_ack) begin
        avs_readdata <= rd_mux;
      end
    end
  end
  assign avs_waitrequest = avs_read && !rd_ack;

  // rate hunt and transceiver sequencing
  assign cand = next_std(rx_std, standard_enable_inputs);
  assign multi = $countones(standard_enable_inputs) > 1;
  // single-standard receivers are never programmed, not even once
  assign need_prog = multi && (!prog_valid
                     || setting_of(cand, triple) != prog_set);
  assign timeout = tmr == 24'(TIMEOUT - 1);
  always_comb begin
    next_state = state;
    case (state)
      S_DETECT: begin
        next_state = need_prog ? S_REQ : S_TRAIN;
      end
      S_REQ: begin
        if (!reconfig_done) begin
          next_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (reconfig_done) begin
          next_state = S_TRAIN;
        end
      end
      S_TRAIN: begin
        if (pll_locked) begin
          next_state = S_LOCK;
        end else if (timeout) begin
          next_state = S_DETECT;
        end
      end
      S_LOCK: begin
        if (sig_present) begin
          next_state = S_RUN;
        end else if (timeout) begin
          next_state = S_DETECT;
        end
      end
      S_RUN: begin
        if (sig_lost) begin
          next_state = S_DETECT;
        end
      end
      default: begin
        next_state = S_DETECT;
      end
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_DETECT;
      tmr <= 24'h00_0000;
    end else begin
      state <= next_state;
      tmr <= (next_state != state) ? 24'h00_0000 : tmr + 24'h00_0001;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_std <= STD_SD;
      prog_set <= STD_SD;
      prog_valid <= 1'b0;
    end else begin
      if (state == S_DETECT) begin
        rx_std <= cand;
      end
      if (state == S_WAIT && reconfig_done) begin
        prog_set <= setting_of(rx_std, triple);
        prog_valid <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      start_reconfig <= 1'b0;
      rx_analog_reset <= 1'b1;
      rx_digital_reset <= 1'b1;
      rx_lock_to_ref <= 1'b1;
      crc_error <= 1'b0;
    end else begin
      start_reconfig <= next_state == S_REQ || next_state == S_WAIT;
      rx_analog_reset <= next_state == S_DETECT || next_state == S_REQ
                         || next_state == S_WAIT;
      rx_digital_reset <= !(next_state == S_LOCK || next_state == S_RUN);
      // sd never tracks data; hd and 3g track once the pll has trained
      rx_lock_to_ref <= rx_std == STD_SD
                        || !(next_state == S_LOCK || next_state == S_RUN);
      crc_error <= crc_error_in || start_reconfig;
    end
  end
  assign rx_lock_to_data = ~rx_lock_to_ref;
  assign path_clr = rx_digital_reset;

  // word aligner: a lone trs at a new position is held pending
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      word_align <= 5'h00;
      pend_align <= 5'h00;
      pend_valid <= 1'b0;
    end else if (trs_seen) begin
      if (trs_align == word_align) begin
        pend_valid <= 1'b0;
      end else if (pend_valid && trs_align == pend_align) begin
        word_align <= trs_align;
        pend_valid <= 1'b0;
      end else begin
        pend_align <= trs_align;
        pend_valid <= 1'b1;
      end
    end
  end
  assign acc = trs_seen && (trs_align == word_align
               || (pend_valid && trs_align == pend_align));
  assign acc_eav = acc && trs_is_eav;
  assign acc_sav = acc && !trs_is_eav;

  // word stamps and line spacing
  assign since = word_cnt - eav_stamp;
  assign line_lim = len_ok ? line_len : LINE_LIMIT_WORDS;
  assign line_end = word_valid && !acc_eav && since == line_lim;
  assign good_eav = acc_eav && len_ok && since == line_len;
  // a misplaced eav while locked counts as a miss, not a new length
  assign miss = (line_end && len_ok) || (acc_eav && trs_locked && !good_eav);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      word_cnt <= 16'h0000;
      eav_stamp <= 16'h0000;
      sav_stamp <= 16'h0000;
    end else begin
      if (word_valid) begin
        word_cnt <= word_cnt + 16'h0001;
      end
      if (acc_eav || line_end) begin
        eav_stamp <= word_cnt;
      end
      if (acc_sav) begin
        sav_stamp <= word_cnt;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      line_len <= 16'h0000;
      len_ok <= 1'b0;
      sav_off <= 16'h0000;
      sav_match <= 1'b0;
    end else if (path_clr) begin
      len_ok <= 1'b0;
      sav_match <= 1'b0;
    end else begin
      if (acc_eav && !good_eav && !trs_locked) begin
        line_len <= since;
        len_ok <= 1'b1;
      end
      if (acc_sav) begin
        sav_off <= since;
        sav_match <= since == sav_off;
      end else if (acc_eav) begin
        sav_match <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      consist <= 3'h0;
      trs_locked <= 1'b0;
      miss_cnt <= 3'h0;
      missed <= 1'b0;
    end else if (path_clr) begin
      consist <= 3'h0;
      trs_locked <= 1'b0;
      miss_cnt <= 3'h0;
      missed <= 1'b0;
    end else if (good_eav && sav_match) begin
      miss_cnt <= 3'h0;
      missed <= 1'b0;
      if (consist != TRS_LOCK_LINES) begin
        consist <= consist + 3'h1;
      end
      if (consist + 3'h1 >= TRS_LOCK_LINES) begin
        trs_locked <= 1'b1;
      end
    end else if (miss && trs_locked) begin
      missed <= 1'b1;
      miss_cnt <= miss_cnt + 3'h1;
      if (miss_cnt + 3'h1 > {1'b0, tol}) begin
        trs_locked <= 1'b0;
        consist <= 3'h0;
      end
    end else if (acc_eav || line_end) begin
      consist <= 3'h0;
    end
  end

  // signal presence
  assign sig_lost = sig_present && lost_lines >= lost_lim;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sig_present <= 1'b0;
      lost_lines <= 8'h00;
    end else if (path_clr) begin
      sig_present <= 1'b0;
      lost_lines <= 8'h00;
    end else begin
      if (acc) begin
        sig_present <= 1'b1;
      end else if (sig_lost) begin
        sig_present <= 1'b0;
      end
      if (acc_eav) begin
        lost_lines <= 8'h00;
      end else if (line_end && lost_lines != 8'hFF) begin
        lost_lines <= lost_lines + 8'h01;
      end
    end
  end

  slr_frame_lock #(
    .STABLE(FRAME_STABLE)
  ) u_frame (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clr(path_clr || !trs_locked),
    .eav(acc_eav),
    .f_bit(f_bit),
    .v_bit(v_bit),
    .frame_locked(frame_locked)
  );

  slr_oversample u_os (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .enable(rx_std == STD_SD),
    .os_factor(triple ? OS_TRIPLE : OS_SD),
    .sample(os_sample),
    .sample_valid(os_sample_valid),
    .sd_bit(sd_bit),
    .sd_bit_valid(sd_bit_valid)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      video_valid <= 1'b0;
    end else begin
      video_valid <= frame_locked && trs_locked;
    end
  end
  assign rx_status = {trs_locked, frame_locked, missed, sig_present};
endmodule // slr_rx_ctrl
`default_nettype wire

// File: tb/slr_rx_ctrl_asserts.sv
// port checker for the receive lock and rate controller
`timescale 1ns/1ns
`default_nettype none
module slr_rx_ctrl_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // transceiver and reconfiguration
  input wire logic pll_locked,
  input wire logic rx_analog_reset,
  input wire logic rx_digital_reset,
  input wire logic rx_lock_to_ref,
  input wire logic rx_lock_to_data,
  input wire logic [1:0] rx_std,
  input wire logic start_reconfig,
  input wire logic reconfig_done,
  input wire logic [2:0] standard_enable_inputs,
  // trs and status
  input wire logic trs_seen,
  input wire logic [3:0] rx_status,
  input wire logic video_valid,
  input wire logic crc_error
);
  import slr_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_req_withdraw: assert property ($fell(start_reconfig) |-> $past(reconfig_done))
    else $error("request withdrawn before done");
  a_resets_held: assert property (
    start_reconfig |-> rx_analog_reset && rx_digital_reset)
    else $error("receive resets not held while reprogramming");
  a_digital_late: assert property (
    $fell(rx_digital_reset) |-> !rx_analog_reset && $past(pll_locked))
    else $error("digital reset released before pll stable");
  a_sd_on_ref: assert property (
    (rx_std == STD_SD) |-> rx_lock_to_ref && !rx_lock_to_data)
    else $error("sd reception not on reference");
  a_crc_reconfig: assert property (start_reconfig |=> crc_error)
    else $error("crc error not shown while reprogramming");
  a_present_cause: assert property ($rose(rx_status[0]) |-> $past(trs_seen))
    else $error("present flag without trs");
  a_frame_drop: assert property ($fell(rx_status[3]) |-> ##[0:2] !rx_status[2])
    else $error("frame lock kept after trs lock loss");
  a_video_cause: assert property (
    video_valid |-> $past(rx_status[2]) && $past(rx_status[3]))
    else $error("video valid without both locks");
  a_multi_only: assert property (
    $rose(start_reconfig) |-> $countones($past(standard_enable_inputs)) > 1)
    else $error("single standard asked for reprogramming");
  a_path_clear: assert property (
    $rose(rx_digital_reset) |-> ##[0:2] rx_status[3:1] == 3'h0)
    else $error("lock flags kept over path reset");
  c_reconfig: cover property ($rose(start_reconfig));
  c_trs_lock: cover property ($rose(rx_status[3]));
  c_frame_lock: cover property ($rose(rx_status[2]));
endmodule // slr_rx_ctrl_asserts
bind slr_rx_ctrl slr_rx_ctrl_asserts chk_u (.clk_sys(clk_sys), .rst_b(rst_b),
  .pll_locked(pll_locked), .rx_analog_reset(rx_analog_reset),
  .rx_digital_reset(rx_digital_reset), .rx_lock_to_ref(rx_lock_to_ref),
  .rx_lock_to_data(rx_lock_to_data), .rx_std(rx_std), .start_reconfig(start_reconfig),
  .reconfig_done(reconfig_done), .standard_enable_inputs(standard_enable_inputs),
  .trs_seen(trs_seen), .rx_status(rx_status), .video_valid(video_valid),
  .crc_error(crc_error));
`default_nettype wire

// File: tb/slr_reconfig_model.sv
// far side model: reconfiguration logic and receive pll
`timescale 1ns/1ns
`default_nettype none
module slr_reconfig_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // device side
  input wire logic start_reconfig,
  input wire logic rx_analog_reset,
  input wire logic slow,
  // answers
  output logic reconfig_done,
  output logic pll_locked
);
  logic [1:0] phase;
  logic [5:0] cnt, pll_cnt, dly;
  assign dly = slow ? 6'h14 : 6'h02;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 2'h0;
      cnt <= 6'h00;
      reconfig_done <= 1'b1;
    end else if (cnt != 6'h00) begin
      cnt <= cnt - 6'h01;
    end else if (phase == 2'h0) begin
      if (start_reconfig) begin
        phase <= 2'h1;
        cnt <= dly;
      end
    end else if (phase == 2'h1) begin
      reconfig_done <= 1'b0;
      phase <= 2'h2;
      cnt <= dly;
    end else if (phase == 2'h2) begin
      reconfig_done <= 1'b1;
      phase <= 2'h3;
    end else if (!start_reconfig) begin
      phase <= 2'h0;
    end
  end
  // pll settles anew after every analog reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) pll_cnt <= 6'h00;
    else if (rx_analog_reset) pll_cnt <= 6'h00;
    else if (!pll_locked) pll_cnt <= pll_cnt + 6'h01;
  end
  assign pll_locked = pll_cnt > dly;
endmodule // slr_reconfig_model
`default_nettype wire

// File: tb/slr_rx_ctrl_tb_top.sv
// bench for the receive lock and rate controller
`timescale 1ns/1ns
`default_nettype none
module slr_rx_ctrl_tb_top;
  import slr_pkg::*;
  logic clk_sys, rst_b, avs_read, avs_write, avs_waitrequest, pll_locked, slow;
  logic rx_analog_reset, rx_digital_reset, rx_lock_to_ref, start_reconfig, reconfig_done;
  logic word_valid, trs_seen, trs_is_eav, f_bit, v_bit, video_valid;
  logic [3:0] avs_address, rx_status;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [1:0] rx_std;
  logic [2:0] standard_enable_inputs;
  logic [4:0] word_align;
  logic os_sample, os_sample_valid, sd_bit, sd_bit_valid;
  logic [7:0] sd_bits;
  int failures, tests_run, ln, req_count, resets, n;
  // short timeout keeps the rate hunt within a few hundred cycles
  slr_rx_ctrl #(.TIMEOUT(200)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pll_locked(pll_locked),
    .rx_analog_reset(rx_analog_reset), .rx_digital_reset(rx_digital_reset),
    .rx_lock_to_ref(rx_lock_to_ref), .rx_lock_to_data(), .rx_std(rx_std),
    .start_reconfig(start_reconfig), .reconfig_done(reconfig_done),
    .standard_enable_inputs(standard_enable_inputs), .os_sample(os_sample),
    .os_sample_valid(os_sample_valid), .sd_bit(sd_bit), .sd_bit_valid(sd_bit_valid),
    .word_valid(word_valid),
    .trs_seen(trs_seen), .trs_is_eav(trs_is_eav), .trs_align(5'h03), .f_bit(f_bit),
    .v_bit(v_bit), .crc_error_in(1'b0), .word_align(word_align), .rx_status(rx_status),
    .video_valid(video_valid), .crc_error());
  slr_reconfig_model model_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .start_reconfig(start_reconfig), .rx_analog_reset(rx_analog_reset), .slow(slow),
    .reconfig_done(reconfig_done), .pll_locked(pll_locked));
  always @(posedge start_reconfig) req_count++;
  always @(posedge rx_digital_reset) resets++;
  always @(posedge clk_sys) if (sd_bit_valid) sd_bits <= {sd_bits[6:0], sd_bit};
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= rd;
    avs_write <= !rd;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_for(input logic lvl);
    while (rx_digital_reset !== lvl) @(negedge clk_sys);
  endtask
  // twelve-word lines, sav four words after eav, eight lines a frame
  task automatic lines(input int cnt, input logic eav_on);
    repeat (cnt) begin
      for (int w = 0; w < 12; w++) begin
        @(posedge clk_sys);
        word_valid <= 1'b1;
        trs_seen <= eav_on && (w == 0 || w == 4);
        trs_is_eav <= (w == 0);
        f_bit <= (ln % 8) >= 4;
        v_bit <= (ln % 8) < 2;
      end
      @(posedge clk_sys);
      word_valid <= 1'b0;
      trs_seen <= 1'b0;
      repeat (2) @(posedge clk_sys);
      ln++;
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    failures++;
    complete_run();
  end
  initial begin
    {rst_b, avs_read, avs_write, slow, word_valid, trs_seen, trs_is_eav, f_bit, v_bit} = 9'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    {os_sample, os_sample_valid} = 2'h0;
    standard_enable_inputs = 3'b011;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    bus(1'b1, ADDR_CTRL, 32'h0);
    check("ctrl_reset", 32'h0000_0820, d);
    bus(1'b1, 4'h2, 32'h0);
    check("unmapped", 32'h0, d);
    bus(1'b0, ADDR_CTRL, 32'h0000_0420);
    bus(1'b1, ADDR_CTRL, 32'h0);
    check("ctrl_write", 32'h0000_0420, d);
    wait_for(1'b0);
    check("std_first", STD_HD, rx_std);
    check("hd_tracks", 0, rx_lock_to_ref);
    check("reqs", 1, req_count);
    wait_for(1'b1);
    wait_for(1'b0);
    check("std_retry", STD_SD, rx_std);
    check("sd_on_ref", 1, rx_lock_to_ref);
    d = 32'h0000_00B2;
    for (int b = 39; b >= 0; b--) begin
      @(posedge clk_sys);
      os_sample <= d[b / 5];
      os_sample_valid <= 1'b1;
    end
    @(posedge clk_sys);
    os_sample_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("sd_bits", 8'hB2, sd_bits);
    slow <= 1'b1;
    wait_for(1'b1);
    wait_for(1'b0);
    check("std_back", STD_HD, rx_std);
    check("reqs", 3, req_count);
    lines(1, 1'b1);
    check("present", 1, rx_status[0]);
    lines(48, 1'b1);
    check("trs_lock", 1, rx_status[3]);
    check("frame_lock", 1, rx_status[2]);
    check("video_valid", 1, video_valid);
    check("align", 5'h03, word_align);
    bus(1'b1, ADDR_STAMP, 32'h0);
    check("stamp_gap", 32'h4, {16'h0, d[31:16] - d[15:0]});
    lines(2, 1'b0);
    check("missed", 1, rx_status[1]);
    check("lock_kept", 1, rx_status[3]);
    lines(1, 1'b1);
    check("missed_clr", 0, rx_status[1]);
    standard_enable_inputs <= 3'b010;
    n = resets;
    lines(4, 1'b0);
    check("lock_lost", 0, rx_status[3]);
    check("frame_lost", 0, rx_status[2]);
    lines(3, 1'b0);
    check("relock", 1, resets - n);
    check("status_clr", 0, rx_status);
    wait_for(1'b0);
    check("no_reprog", 3, req_count);
    check("std_kept", STD_HD, rx_std);
    complete_run();
  end
endmodule // slr_rx_ctrl_tb_top
`default_nettype wire
